// ### logic/ccd_defs.svh
// Notes on behaviour
// - Clear-accumulator loads zero into the accumulator and sets the zero flag.
// - Clear-watchdog sets timeout and powerdown flags; encoding ends 0110 0100.
// - Clear-watchdog zeroes the watchdog count and its assigned prescaler.
// - Decrement computes register minus one, writes destination, updates zero flag.
// - Destination bit 0 writes the accumulator; file register stays unchanged.
// - Destination bit 1 writes the result back into the addressed register.
// - Register address is low 7 bits; destination bit sits just above.
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH

// ==========================================================================
// Encodings
// ==========================================================================
`define CCD_OP_CLRACC   14'h0103
`define CCD_OP_CLRWDOG  14'h0064
`define CCD_OPC_INV     6'h09
`define CCD_OPC_DEC     6'h03
`define CCD_OPC_MSB     13
`define CCD_OPC_LSB     8
`define CCD_DEST_BIT    7
`define CCD_ADDR_MSB    6

// ==========================================================================
// APB map
// ==========================================================================
`define CCD_REG_INSN    12'h000
`define CCD_REG_ACC     12'h004
`define CCD_REG_STATUS  12'h008
`define CCD_REG_WDOG    12'h00C
`define CCD_REG_FILE    12'h100
`define CCD_FILE_END    12'h2FC
`define CCD_ST_ZERO     0
`define CCD_ST_PD       1
`define CCD_ST_TO       2
`define CCD_WDOG_PRE_W  8

`endif

// ### logic/ccd_pkg.sv
package ccd_pkg;
  typedef enum logic [2:0] {
    CCD_NONE, CCD_CLRACC, CCD_CLRWDOG, CCD_INV, CCD_DEC
  } ccd_op_t;
endpackage : ccd_pkg

// ### logic/ccd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defs.svh"
module ccd_decode (
  // Instruction
  input  wire logic [13:0]       insn,
  // Decoded fields
  output var ccd_pkg::ccd_op_t   op,
  output wire logic              dest,
  output wire logic [6:0]        addr
);
  // ========================================================================
  // Field extraction
  // ========================================================================
  wire logic [5:0] opc;
  assign opc  = insn[`CCD_OPC_MSB:`CCD_OPC_LSB];
  assign dest = insn[`CCD_DEST_BIT];
  assign addr = insn[`CCD_ADDR_MSB:0];
  assign op   = (insn == `CCD_OP_CLRACC)  ? ccd_pkg::CCD_CLRACC  :
                (insn == `CCD_OP_CLRWDOG) ? ccd_pkg::CCD_CLRWDOG :
                (opc == `CCD_OPC_INV)     ? ccd_pkg::CCD_INV     :
                (opc == `CCD_OPC_DEC)     ? ccd_pkg::CCD_DEC     :
                                            ccd_pkg::CCD_NONE;
endmodule : ccd_decode
`default_nettype wire

// ### logic/ccd_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defs.svh"
module ccd_exec #(
  parameter int WDOG_W = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Watchdog tick from the surrounding core
  input  wire logic              wdog_tick,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Flags
  output logic                   zero_flag,
  output logic                   timeout_flag,
  output logic                   powerdown_flag
);
  // ========================================================================
  // State
  // ========================================================================
  logic [7:0]                  acc_q;
  logic [7:0]                  file_q [128];
  logic [WDOG_W-1:0]           wdog_q;
  logic [`CCD_WDOG_PRE_W-1:0]  pre_q;
  logic                        pready_q;
  logic [31:0]                 prdata_q;
  logic                        pslverr_q;

  // ========================================================================
  // Bus decode
  // ========================================================================
  wire logic        acc_en;
  wire logic        wr_en;
  wire logic        rd_en;
  wire logic        hit_insn;
  wire logic        hit_acc;
  wire logic        hit_st;
  wire logic        hit_wd;
  wire logic        file_lo;
  wire logic        file_hi;
  wire logic        file_algn;
  wire logic        hit_file;
  wire logic        hit_any;
  wire logic [11:0] file_off;
  wire logic [6:0]  bus_idx;
  assign acc_en    = psel & penable & ~pready_q;
  assign wr_en     = acc_en & pwrite;
  assign rd_en     = acc_en & ~pwrite;
  assign hit_insn  = paddr == `CCD_REG_INSN;
  assign hit_acc   = paddr == `CCD_REG_ACC;
  assign hit_st    = paddr == `CCD_REG_STATUS;
  assign hit_wd    = paddr == `CCD_REG_WDOG;
  // File window: one aligned word per register
  assign file_off  = paddr - `CCD_REG_FILE;
  assign file_lo   = paddr >= `CCD_REG_FILE;
  assign file_hi   = paddr <= `CCD_FILE_END;
  assign file_algn = paddr[1:0] == 2'h0;
  assign hit_file  = file_lo & file_hi & file_algn;
  assign hit_any   = hit_insn | hit_acc | hit_st | hit_wd | hit_file;
  assign bus_idx   = file_off[8:2];

  // ========================================================================
  // Instruction decode and datapath
  // ========================================================================
  ccd_pkg::ccd_op_t op;
  wire logic        dest;
  wire logic [6:0]  addr;
  ccd_decode u_dec (
    .insn (pwdata[13:0]),
    .op   (op),
    .dest (dest),
    .addr (addr)
  );

  wire logic        exec;
  wire logic        is_clracc;
  wire logic        is_clrwdog;
  wire logic        is_inv;
  wire logic        is_dec;
  wire logic        is_file_op;
  wire logic [7:0]  src;
  wire logic [7:0]  result;
  wire logic        to_file;
  wire logic        to_acc;
  assign exec       = wr_en & hit_insn;
  assign is_clracc  = op == ccd_pkg::CCD_CLRACC;
  assign is_clrwdog = op == ccd_pkg::CCD_CLRWDOG;
  assign is_inv     = op == ccd_pkg::CCD_INV;
  assign is_dec     = op == ccd_pkg::CCD_DEC;
  assign is_file_op = is_inv | is_dec;
  assign src        = file_q[addr];
  assign result     = is_dec ? 8'(src - 8'h01) :
                      is_inv ? ~src :
                               8'h00;
  assign to_file    = exec & is_file_op & dest;
  assign to_acc     = exec & ((is_file_op & ~dest) | is_clracc);

  // ========================================================================
  // Accumulator and file registers
  // ========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 8'h00;
    end else if (to_acc) begin
      acc_q <= result;
    end else if (wr_en & hit_acc) begin
      acc_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 128; i++) file_q[i] <= 8'h00;
    end else if (to_file) begin
      file_q[addr] <= result;
    end else if (wr_en & hit_file) begin
      file_q[bus_idx] <= pwdata[7:0];
    end
  end

  // ========================================================================
  // Status flags
  // ========================================================================
  wire logic clr_wd;
  wire logic upd_zero;
  wire logic st_wr;
  wire logic zero_d;
  assign clr_wd   = exec & is_clrwdog;
  assign upd_zero = exec & (is_file_op | is_clracc);
  assign st_wr    = wr_en & hit_st;
  assign zero_d   = result == 8'h00;

  // Zero flag: instruction result over direct status write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_flag <= 1'b0;
    end else if (upd_zero) begin
      zero_flag <= zero_d;
    end else if (st_wr) begin
      zero_flag <= pwdata[`CCD_ST_ZERO];
    end
  end

  // Clear-watchdog wins over a direct status write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= 1'b1;
    end else if (clr_wd) begin
      timeout_flag <= 1'b1;
    end else if (st_wr) begin
      timeout_flag <= pwdata[`CCD_ST_TO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerdown_flag <= 1'b1;
    end else if (clr_wd) begin
      powerdown_flag <= 1'b1;
    end else if (st_wr) begin
      powerdown_flag <= pwdata[`CCD_ST_PD];
    end
  end

  // ========================================================================
  // Watchdog counter and prescaler
  // ========================================================================
  localparam int PRE_W = `CCD_WDOG_PRE_W;
  wire logic pre_wrap;
  assign pre_wrap = wdog_tick & (&pre_q);

  // Prescaler steps on every tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (clr_wd) begin
      pre_q <= '0;
    end else if (wdog_tick) begin
      pre_q <= PRE_W'(pre_q + 1'b1);
    end
  end

  // Count steps when the prescaler wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_q <= '0;
    end else if (clr_wd) begin
      wdog_q <= '0;
    end else if (pre_wrap) begin
      wdog_q <= WDOG_W'(wdog_q + 1'b1);
    end
  end

  // ========================================================================
  // Read mux and bus answer
  // ========================================================================
  wire logic [31:0] rd_val;
  assign rd_val = hit_acc  ? {24'h000000, acc_q} :
                  hit_st   ? {29'h0, timeout_flag, powerdown_flag, zero_flag} :
                  hit_wd   ? 32'({pre_q, wdog_q}) :
                  hit_file ? {24'h000000, file_q[bus_idx]} :
                             32'h00000000;

  // One-cycle answer after the first access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= acc_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= acc_en & ~hit_any;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (rd_en) begin
      prdata_q <= rd_val;
    end
  end
  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
endmodule : ccd_exec
`default_nettype wire

// ### testbench/ccd_exec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_exec_assertions #(
  parameter int WDOG_W = 8
) (
  input wire logic        pclk, presetn, wdog_tick, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        pready, pslverr, zero_flag, timeout_flag, powerdown_flag
);
  wire logic acc = psel && penable && !pready;
  wire logic ex  = acc && pwrite && paddr == 12'h000;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  clr_acc_a: assert property (ex && pwdata[13:0] == 14'h0103 |=> zero_flag)
    else $error("zero flag not set");
  clr_wdog_a: assert property (ex && pwdata[13:0] == 14'h0064 |=> timeout_flag && powerdown_flag)
    else $error("status flags not set");
  ready_time_a: assert property (acc |=> pready) else $error("late ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  err_pair_a: assert property (pslverr |-> pready) else $error("lone error");
  unmap_err_a: assert property (acc && paddr[11:8] == 4'h0 && paddr > 12'h00C |=> pslverr)
    else $error("no error");
  map_ok_a: assert property (acc && paddr <= 12'h00C |=> !pslverr) else $error("false error");
  file_map_a: assert property (acc && paddr >= 12'h100 && paddr <= 12'h2FC && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("file slot refused");
  insn_rd_a: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata == 32'h0)
    else $error("insn read not zero");
  cover property (ex && pwdata[13:8] == 6'h09);
  cover property (ex && pwdata[13:8] == 6'h03);
  cover property (pslverr);
endmodule : ccd_exec_assertions
bind ccd_exec ccd_exec_assertions #(.WDOG_W(WDOG_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .wdog_tick(wdog_tick), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .zero_flag(zero_flag),
  .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
`default_nettype wire

// ### testbench/ccd_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_core_model (
  input wire logic  pclk, presetn, run,
  output var logic  wdog_tick
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_tick <= 1'b0;
    end else begin
      wdog_tick <= run;
    end
  end
endmodule : ccd_core_model
`default_nettype wire

// ### testbench/clear_complement_decrement_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clear_complement_decrement_exec_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, e;
  logic wdog_tick, pready, pslverr, zero_flag, timeout_flag, powerdown_flag;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  int          error_cnt = 0, compares = 0;
  always #2.5 pclk = ~pclk;
  ccd_exec dut (.pclk(pclk), .presetn(presetn), .wdog_tick(wdog_tick), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zero_flag(zero_flag), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
  ccd_core_model u_core (.pclk(pclk), .presetn(presetn), .run(run), .wdog_tick(wdog_tick));
  task report_and_stop;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (k == 20) chk("pready", 1, 0);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task t_clracc;
    apb(1, 12'h004, 32'h5A); apb(1, 12'h000, 32'h0103);
    apb(0, 12'h004, 0); chk("acc", 32'h0, r);
    apb(0, 12'h008, 0); chk("zero", 1, r[0]);
    chk("zero_pin", 1, zero_flag);
    apb(0, 12'h000, 0); chk("insn_rd", 32'h0, r);
  endtask : t_clracc
  task t_inv;
    apb(1, 12'h14C, 32'h13); apb(1, 12'h000, 32'h0913);
    apb(0, 12'h004, 0); chk("acc", 32'hEC, r);
    apb(0, 12'h14C, 0); chk("file", 32'h13, r);
    apb(1, 12'h2FC, 32'hFF); apb(1, 12'h000, 32'h09FF);
    apb(0, 12'h2FC, 0); chk("file", 32'h0, r);
    apb(0, 12'h008, 0); chk("zero", 1, r[0]);
  endtask : t_inv
  task t_dec;
    apb(1, 12'h104, 32'h1); apb(1, 12'h000, 32'h0381);
    apb(0, 12'h104, 0); chk("file", 32'h0, r);
    apb(0, 12'h008, 0); chk("zero", 1, r[0]);
    apb(1, 12'h000, 32'h0301);
    apb(0, 12'h004, 0); chk("acc", 32'hFF, r);
    apb(0, 12'h008, 0); chk("zero", 0, r[0]);
  endtask : t_dec
  task t_wdog;
    apb(1, 12'h008, 0);
    run <= 1;
    repeat (600) @(posedge pclk);
    run <= 0;
    repeat (3) @(posedge pclk);
    apb(0, 12'h00C, 0); chk("wdog_run", 32'h5802, r);
    apb(1, 12'h000, 32'h0064);
    apb(0, 12'h00C, 0); chk("wdog", 32'h0, r);
    apb(0, 12'h008, 0); chk("to_pd", 3, r[2:1]);
    chk("to_pin", 1, timeout_flag);
    chk("pd_pin", 1, powerdown_flag);
    apb(0, 12'h010, 0); chk("slverr", 1, e);
  endtask : t_wdog
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    chk("to_rst", 1, timeout_flag);
    chk("pd_rst", 1, powerdown_flag);
    chk("zero_rst", 0, zero_flag);
    t_clracc(); t_inv(); t_dec(); t_wdog();
    report_and_stop();
  end
endmodule : clear_complement_decrement_exec_tb
`default_nettype wire
